// >>> logic/pcg_pkg.sv
// package: register map, field positions, reset values and power states for peripheral clock gating
package pcg_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses within system control)
    // ------------------------------------------------------------
    localparam logic [11:0] RUN_CLOCK_CONFIG_OFS = 12'h060;
    localparam logic [11:0] RUN_PORT_GATE_OFS = 12'h108;
    localparam logic [11:0] SLEEP_PORT_GATE_OFS = 12'h118;
    localparam logic [11:0] DEEPSLEEP_PERIPH_GATE_1_OFS = 12'h124;
    localparam logic [11:0] DEEPSLEEP_PORT_GATE_OFS = 12'h128;
    localparam logic [11:0] FAULT_STATUS_OFS = 12'h200;
    localparam logic [11:0] FAULT_MASK_OFS = 12'h204;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RUN_PORT_GATE_RST = 32'h00000000;
    localparam logic [31:0] DEEPSLEEP_PERIPH_GATE_1_RST = 32'h00000000;
    localparam logic [31:0] GATE_RST = 32'h00000000;

    // ------------------------------------------------------------
    // writable field masks
    // ------------------------------------------------------------
    localparam logic [31:0] PORT_GATE_MASK = 32'h0000001f;
    localparam logic [31:0] PERIPH_GATE_1_MASK = 32'h01070113;

    // port gate bits
    localparam int PORT_A_GATE_BIT = 0;
    localparam int PORT_B_GATE_BIT = 1;
    localparam int PORT_C_GATE_BIT = 2;
    localparam int PORT_D_GATE_BIT = 3;
    localparam int PORT_E_GATE_BIT = 4;
    localparam int NUM_PORTS = 5;

    // peripheral gate bits
    localparam int ASYNC_SERIAL0_GATE_BIT = 0;
    localparam int ASYNC_SERIAL1_GATE_BIT = 1;
    localparam int SYNC_SERIAL0_GATE_BIT = 4;
    localparam int QUAD_DECODER0_GATE_BIT = 8;
    localparam int GP_COUNTER0_GATE_BIT = 16;
    localparam int GP_COUNTER1_GATE_BIT = 17;
    localparam int GP_COUNTER2_GATE_BIT = 18;
    localparam int COMPARATOR0_GATE_BIT = 24;

    // run clock config: automatic gating select
    localparam int AUTO_GATING_SELECT_BIT = 27;
    localparam logic [31:0] RUN_CLOCK_CONFIG_MASK = 32'h08000000;

    // fault status: bit 0 port access fault, bit 1 peripheral access fault
    localparam int FAULT_PORT_BIT = 0;
    localparam int FAULT_PERIPH_BIT = 1;
    localparam logic [31:0] FAULT_MASK_BITS = 32'h00000003;

    // unit select indices: 0..4 ports, 5..12 peripherals
    localparam int NUM_UNITS = 13;
    localparam int UNIT_W = 4;

    // power states
    typedef enum logic [1:0] {
        PCG_RUN,
        PCG_SLEEP,
        PCG_DEEP
    } pcg_power_t;

endpackage

// >>> logic/pcg_clock_cell.sv
// glitch-free clock gating cell with latched enable
`timescale 1ns/1ps

module pcg_clock_cell (
    // clock and enable
    input wire logic clk_in,
    input wire logic enable,
    // gated clock
    output logic clk_out
);

    logic en_latch;

    // enable only moves while clock is low, so no truncated high phase
    always_latch begin
        if (!clk_in) begin
            en_latch <= enable;
        end
    end

    assign clk_out = clk_in & en_latch;

endmodule

// >>> logic/pcg_top.sv
// peripheral clock gating control: gating registers, power state selection, access fault
// Functional notes
// - gating bit one supplies unit clock; zero stops clock and disables unit.
// - access to a unit whose clock is gated off answers with bus fault.
// - run port gating register resets to zero; all ports start unclocked.
// - run, sleep or deep-sleep gating register chosen by current power state.
// - sleep and deep-sleep registers apply only when automatic gating is set.
// - run port gating bits 0 to 4 gate ports a to e, rw, reset zero.
// - run port gating bits 31:5 read zero; software preserves them.
// - deep-sleep peripheral bit 16 gates counter 0, rw, reset zero.
// - deep-sleep peripheral bit 8 gates quadrature decoder 0, rw, reset zero.
// - deep-sleep peripheral bit 4 gates synchronous serial 0, rw, reset zero.
// - deep-sleep peripheral bits 1 and 0 gate async serial 1 and 0.
// - deep-sleep peripheral bits 15:9, 7:5, 3:2 read zero.
// - deep-sleep peripheral register at 0x124, 32 bits, resets zero.
// - deep-sleep peripheral bit 24 gates comparator, bits 18, 17 counters.
`timescale 1ns/1ps

module pcg_top
    import pcg_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // power state from power controller
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    // unit access from bus fabric
    input wire logic unit_access,
    input wire logic [3:0] unit_sel,
    output logic unit_fault,
    // gated unit clocks and enables
    output logic [4:0] port_clk,
    output logic [4:0] port_enable,
    output logic [7:0] periph_clk,
    output logic [7:0] periph_enable,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] run_port_clock_gate_q;
    logic [31:0] sleep_port_clock_gate_q;
    logic [31:0] deepsleep_port_clock_gate_q;
    logic [31:0] deepsleep_periph_clock_gate_1_q;
    logic [31:0] run_clock_config_q;
    logic [31:0] fault_status_q;
    logic [31:0] fault_mask_q;
    logic [31:0] reg_rdata_q;
    logic unit_fault_q;
    logic sleep_s1_q;
    logic sleep_s2_q;
    logic deep_s1_q;
    logic deep_s2_q;
    pcg_power_t power_q;
    logic auto_gating_select;
    logic [4:0] port_gate;
    logic [7:0] periph_gate;
    logic [7:0] periph_run;
    logic [7:0] periph_deep;
    logic [NUM_UNITS-1:0] unit_on;
    logic [31:0] fault_set;
    logic wr_run;
    logic wr_sleep;
    logic wr_deep;
    logic wr_periph;
    logic wr_cfg;
    logic wr_status;
    logic wr_mask;
    logic [NUM_UNITS-1:0] unit_hit;
    logic [NUM_UNITS-1:0] unit_miss;
    logic port_miss;
    logic periph_miss;

    // one decode per register; the slave never stalls the master
    assign wr_run = reg_wr && (reg_addr == RUN_PORT_GATE_OFS);
    assign wr_sleep = reg_wr && (reg_addr == SLEEP_PORT_GATE_OFS);
    assign wr_deep = reg_wr && (reg_addr == DEEPSLEEP_PORT_GATE_OFS);
    assign wr_periph = reg_wr && (reg_addr == DEEPSLEEP_PERIPH_GATE_1_OFS);
    assign wr_cfg = reg_wr && (reg_addr == RUN_CLOCK_CONFIG_OFS);
    assign wr_status = reg_wr && (reg_addr == FAULT_STATUS_OFS);
    assign wr_mask = reg_wr && (reg_addr == FAULT_MASK_OFS);

    // ------------------------------------------------------------
    // gating registers
    // ------------------------------------------------------------
    // run ports reset off
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            run_port_clock_gate_q <= RUN_PORT_GATE_RST;
        end else if (wr_run) begin
            run_port_clock_gate_q <= reg_wdata & PORT_GATE_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sleep_port_clock_gate_q <= GATE_RST;
        end else if (wr_sleep) begin
            sleep_port_clock_gate_q <= reg_wdata & PORT_GATE_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            deepsleep_port_clock_gate_q <= GATE_RST;
        end else if (wr_deep) begin
            deepsleep_port_clock_gate_q <= reg_wdata & PORT_GATE_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            deepsleep_periph_clock_gate_1_q <= DEEPSLEEP_PERIPH_GATE_1_RST;
        end else if (wr_periph) begin
            deepsleep_periph_clock_gate_1_q <= reg_wdata & PERIPH_GATE_1_MASK;
        end
    end

    // only the automatic gating bit of this register is kept here
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            run_clock_config_q <= GATE_RST;
        end else if (wr_cfg) begin
            run_clock_config_q <= reg_wdata & RUN_CLOCK_CONFIG_MASK;
        end
    end

    assign auto_gating_select = run_clock_config_q[AUTO_GATING_SELECT_BIT];

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    // requests come from another domain, so two flops first
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sleep_s1_q <= 1'b0;
            sleep_s2_q <= 1'b0;
        end else begin
            sleep_s1_q <= sleep_req;
            sleep_s2_q <= sleep_s1_q;
        end
    end

    // deep-sleep request has its own pair of flops
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            deep_s1_q <= 1'b0;
            deep_s2_q <= 1'b0;
        end else begin
            deep_s1_q <= deep_sleep_req;
            deep_s2_q <= deep_s1_q;
        end
    end

    // deep sleep wins over sleep when both are asked
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            power_q <= PCG_RUN;
        end else if (deep_s2_q) begin
            power_q <= PCG_DEEP;
        end else if (sleep_s2_q) begin
            power_q <= PCG_SLEEP;
        end else begin
            power_q <= PCG_RUN;
        end
    end

    // ------------------------------------------------------------
    // gate selection
    // ------------------------------------------------------------
    // run and sleep settings for register 1 are outside this block: peripherals run ungated then
    assign periph_run = 8'hff;

    generate
        for (genvar p = 0; p < 8; p++) begin : g_deep
            localparam int PB = (p == 0) ? ASYNC_SERIAL0_GATE_BIT :
                                (p == 1) ? ASYNC_SERIAL1_GATE_BIT :
                                (p == 2) ? SYNC_SERIAL0_GATE_BIT :
                                (p == 3) ? QUAD_DECODER0_GATE_BIT :
                                (p == 4) ? GP_COUNTER0_GATE_BIT :
                                (p == 5) ? GP_COUNTER1_GATE_BIT :
                                (p == 6) ? GP_COUNTER2_GATE_BIT : COMPARATOR0_GATE_BIT;
            assign periph_deep[p] = deepsleep_periph_clock_gate_1_q[PB];
        end
    endgenerate

    always_comb begin
        port_gate = run_port_clock_gate_q[NUM_PORTS-1:0];
        periph_gate = periph_run;
        case (power_q)
            PCG_RUN: begin
                port_gate = run_port_clock_gate_q[NUM_PORTS-1:0];
                periph_gate = periph_run;
            end
            PCG_SLEEP: begin
                // register 1 has no sleep copy, so peripherals keep their run setting
                if (auto_gating_select) begin
                    port_gate = sleep_port_clock_gate_q[NUM_PORTS-1:0];
                end
            end
            PCG_DEEP: begin
                if (auto_gating_select) begin
                    port_gate = deepsleep_port_clock_gate_q[NUM_PORTS-1:0];
                    periph_gate = periph_deep;
                end
            end
            default: begin
                port_gate = run_port_clock_gate_q[NUM_PORTS-1:0];
                periph_gate = periph_run;
            end
        endcase
    end

    assign unit_on = {periph_gate, port_gate};
    assign port_enable = port_gate;
    assign periph_enable = periph_gate;

    // ------------------------------------------------------------
    // gated clocks
    // ------------------------------------------------------------
    // enables move just after the rising edge; each cell holds the old one through the high phase
    // clock follows gate bit
    generate
        for (genvar u = 0; u < NUM_UNITS; u++) begin : g_cell
            logic gclk;
            pcg_clock_cell u_cell (
                .clk_in(ref_clk),
                .enable(unit_on[u]),
                .clk_out(gclk)
            );
            if (u < NUM_PORTS) begin : g_port
                assign port_clk[u] = gclk;
            end else begin : g_periph
                assign periph_clk[u-NUM_PORTS] = gclk;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // access fault
    // ------------------------------------------------------------
    // fault on unclocked access
    // one decoded select per unit, so a select past the last unit hits nothing
    generate
        for (genvar h = 0; h < NUM_UNITS; h++) begin : g_hit
            assign unit_hit[h] = unit_access && (unit_sel == UNIT_W'(h));
            assign unit_miss[h] = unit_hit[h] && !unit_on[h];
        end
    endgenerate

    assign port_miss = |unit_miss[NUM_PORTS-1:0];
    assign periph_miss = |unit_miss[NUM_UNITS-1:NUM_PORTS];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            unit_fault_q <= 1'b0;
        end else begin
            unit_fault_q <= port_miss || periph_miss;
        end
    end

    assign unit_fault = unit_fault_q;

    // status bit by kind of unit: ports or peripherals
    always_comb begin
        fault_set = 32'h00000000;
        fault_set[FAULT_PORT_BIT] = port_miss;
        fault_set[FAULT_PERIPH_BIT] = periph_miss;
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    // a new fault in the clearing cycle stays set
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fault_status_q <= GATE_RST;
        end else if (wr_status) begin
            fault_status_q <= ((fault_status_q & ~reg_wdata) | fault_set) & FAULT_MASK_BITS;
        end else begin
            fault_status_q <= (fault_status_q | fault_set) & FAULT_MASK_BITS;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fault_mask_q <= GATE_RST;
        end else if (wr_mask) begin
            fault_mask_q <= reg_wdata & FAULT_MASK_BITS;
        end
    end

    // level output: stays high until software clears or masks the cause
    assign irq = |(fault_status_q & fault_mask_q);

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    // unmapped addresses read zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                RUN_CLOCK_CONFIG_OFS: reg_rdata_q <= run_clock_config_q;
                RUN_PORT_GATE_OFS: reg_rdata_q <= run_port_clock_gate_q;
                SLEEP_PORT_GATE_OFS: reg_rdata_q <= sleep_port_clock_gate_q;
                DEEPSLEEP_PERIPH_GATE_1_OFS: reg_rdata_q <= deepsleep_periph_clock_gate_1_q;
                DEEPSLEEP_PORT_GATE_OFS: reg_rdata_q <= deepsleep_port_clock_gate_q;
                FAULT_STATUS_OFS: reg_rdata_q <= fault_status_q;
                FAULT_MASK_OFS: reg_rdata_q <= fault_mask_q;
                default: reg_rdata_q <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end

    assign reg_rdata = reg_rdata_q;

endmodule

// >>> tb/pcg_checker.sv
// checker: concurrent assertions on the clock gating block ports
`timescale 1ns/1ps

module pcg_checker
    import pcg_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // power and unit access
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic unit_access,
    input wire logic [3:0] unit_sel,
    input wire logic unit_fault,
    // unit clocks, enables, interrupt
    input wire logic [4:0] port_clk,
    input wire logic [4:0] port_enable,
    input wire logic [7:0] periph_clk,
    input wire logic [7:0] periph_enable,
    input wire logic irq
);
    logic unit_on;
    logic [3:0] periph_idx;
    assign periph_idx = unit_sel - 4'h5;
    // selects 13..15 name no unit, so they never fault
    assign unit_on = (unit_sel < 4'h5) ? port_enable[unit_sel[2:0]] :
        (unit_sel < 4'hd) ? periph_enable[periph_idx[2:0]] : 1'b1;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_rdata_idle_zero:
        assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not zero when idle");
    chk_port_resv_zero:
        assert property ($past(reg_rd) && $past(reg_addr) == RUN_PORT_GATE_OFS |-> reg_rdata[31:5] == 27'h0)
        else $error("port gate reserved bits not zero");
    chk_periph_resv_zero:
        assert property ($past(reg_rd) && $past(reg_addr) == DEEPSLEEP_PERIPH_GATE_1_OFS
            |-> (reg_rdata & 32'hfef8feec) == 32'h0) else $error("periph gate reserved bits not zero");
    chk_fault_when_off:
        assert property (unit_access && !unit_on |=> unit_fault) else $error("no fault on gated unit");
    chk_no_fault_on:
        assert property (unit_access && unit_on |=> !unit_fault) else $error("fault on clocked unit");
    chk_fault_has_cause:
        assert property (!unit_access |=> !unit_fault) else $error("fault without access");
    chk_irq_has_cause:
        assert property ($rose(irq) |-> unit_fault || $past(reg_wr)) else $error("interrupt without cause");
    chk_reset_clears:
        assert property (disable iff (1'b0) sys_rst |=> port_enable == 5'h0 && reg_rdata == 32'h0 && !irq)
        else $error("state not cleared by reset");
    chk_run_write_applies:
        assert property ((!sleep_req && !deep_sleep_req)[*4] ##0 (reg_wr && reg_addr == RUN_PORT_GATE_OFS)
            |=> port_enable == $past(reg_wdata[4:0])) else $error("run port write not applied");
    chk_clk_follows_gate:
        assert property (@(negedge ref_clk) {port_clk, periph_clk} == $past({port_enable, periph_enable}))
        else $error("gated clock does not follow its enable");

    cover property (unit_access && !unit_on ##1 unit_fault);
    cover property ($rose(irq));
    cover property (deep_sleep_req[*4] ##0 unit_access);
endmodule

bind pcg_top pcg_checker pcg_checker_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
    .unit_access(unit_access), .unit_sel(unit_sel), .unit_fault(unit_fault), .port_clk(port_clk),
    .port_enable(port_enable), .periph_clk(periph_clk), .periph_enable(periph_enable), .irq(irq)
);

// >>> tb/pcg_top_tb.sv
// testbench: registers, faults, interrupt and power states of the clock gating block
`timescale 1ns/1ps

module pcg_top_tb
    import pcg_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst, reg_wr, reg_rd, sleep_req, deep_sleep_req, unit_access, unit_fault, irq;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [3:0] unit_sel;
    logic [4:0] port_clk, port_enable;
    logic [7:0] periph_clk, periph_enable;
    int miscompares = 0;
    int n_tests = 0;
    logic [11:0] map [8] = '{12'h060, 12'h108, 12'h118, 12'h124, 12'h128, 12'h200, 12'h204, 12'h3fc};
    int pbit [8] = '{0, 1, 4, 8, 16, 17, 18, 24};

    pcg_top pcg_top_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
        .unit_access(unit_access), .unit_sel(unit_sel), .unit_fault(unit_fault), .port_clk(port_clk),
        .port_enable(port_enable), .periph_clk(periph_clk), .periph_enable(periph_enable), .irq(irq)
    );

    always #2.5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic access(input logic [3:0] s, input logic f);
        @(posedge ref_clk);
        unit_sel <= s;
        unit_access <= 1'b1;
        @(posedge ref_clk);
        unit_access <= 1'b0;
        #1;
        check({31'h0, unit_fault}, {31'h0, f});
    endtask

    task automatic flag(input logic v);
        #1;
        check({31'h0, irq}, {31'h0, v});
    endtask

    // enables, then gated clocks in the high and the low phase
    task automatic en(input logic [4:0] p, input logic [7:0] q);
        @(posedge ref_clk);
        #1;
        check({19'h0, port_enable, periph_enable}, {19'h0, p, q});
        check({19'h0, port_clk, periph_clk}, {19'h0, p, q});
        #2;
        check({19'h0, port_clk, periph_clk}, 32'h0);
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, sleep_req, deep_sleep_req, unit_access} = 5'h0;
        reg_addr = 12'h0;
        reg_wdata = 32'h0;
        unit_sel = 4'h0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wr(12'h3fc, 32'hffffffff);
        for (int i = 0; i < 8; i++) rd(map[i], 32'h0);
        en(5'h00, 8'hff);
        for (int i = 0; i < 5; i++) begin
            wr(RUN_PORT_GATE_OFS, 32'hffffffe0 | (32'h1 << i));
            rd(RUN_PORT_GATE_OFS, 32'h1 << i);
            en(5'h1 << i, 8'hff);
            for (int j = 0; j < 5; j++) access(j[3:0], j != i);
        end
        access(4'h5, 1'b0);
        flag(1'b0);
        wr(DEEPSLEEP_PERIPH_GATE_1_OFS, 32'hffffffff);
        rd(DEEPSLEEP_PERIPH_GATE_1_OFS, 32'h01070113);
        rd(FAULT_STATUS_OFS, 32'h1);
        wr(FAULT_MASK_OFS, 32'h3);
        flag(1'b1);
        // write one clears the status bit
        wr(FAULT_STATUS_OFS, 32'h1);
        flag(1'b0);
        wr(RUN_PORT_GATE_OFS, 32'h1f);
        wr(SLEEP_PORT_GATE_OFS, 32'h3);
        wr(DEEPSLEEP_PORT_GATE_OFS, 32'h4);
        sleep_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        en(5'h1f, 8'hff);
        wr(RUN_CLOCK_CONFIG_OFS, 32'h08000000);
        en(5'h03, 8'hff);
        @(posedge ref_clk);
        deep_sleep_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int k = 0; k < 8; k++) begin
            wr(DEEPSLEEP_PERIPH_GATE_1_OFS, 32'h1 << pbit[k]);
            en(5'h04, 8'h1 << k);
        end
        wr(DEEPSLEEP_PERIPH_GATE_1_OFS, 32'h10);
        access(4'h5, 1'b1);
        access(4'h7, 1'b0);
        access(4'h2, 1'b0);
        flag(1'b1);
        rd(FAULT_STATUS_OFS, 32'h2);
        // a new fault in the clearing cycle wins over the clear
        @(posedge ref_clk);
        {unit_sel, reg_addr, reg_wdata} <= {4'h5, FAULT_STATUS_OFS, 32'h2};
        {unit_access, reg_wr} <= 2'b11;
        @(posedge ref_clk);
        {unit_access, reg_wr} <= 2'b00;
        rd(FAULT_STATUS_OFS, 32'h2);
        @(posedge ref_clk);
        {sleep_req, deep_sleep_req} <= 2'b00;
        repeat (3) @(posedge ref_clk);
        en(5'h1f, 8'hff);
        // deep sleep without automatic gating keeps the run settings
        wr(RUN_CLOCK_CONFIG_OFS, 32'h0);
        deep_sleep_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        en(5'h1f, 8'hff);
        // second reset in mid-run
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(RUN_PORT_GATE_OFS, 32'h0);
        rd(DEEPSLEEP_PERIPH_GATE_1_OFS, 32'h0);
        flag(1'b0);
        en(5'h00, 8'hff);
        conclude();
    end

    // hang guard: the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        conclude();
    end
endmodule
